// >>> design/arb_pkg.sv
// Constants and types of the bus requester and interrupter block
// =============================================================
// Notes on behaviour
// [RULE1] Firmware DMA request drives the bus request of the chosen level.
// [RULE2] Requester works on any one of four arbitration levels.
// [RULE3] Request without grant for one second aborts and flags an error.
// [RULE4] Bus request stays on until a grant arrives, even if withdrawn.
// [RULE5] On grant, wait address strobe idle, then busy on, request off.
// [RULE6] A bus tenure never lasts beyond 64 microseconds; busy stays on for TENURE_CYC + 1 cycles, and then until grant goes inactive.
// [RULE7] Mastership kept until done; other requests and bus clear ignored.
// [RULE8] After DMA request ends, wait grant inactive, then drop busy.
// [RULE9] Grants seen while idle pass down the chain while grant is low.
// [RULE10] Interrupter works on any one of the seven levels.
// [RULE11] Host programs the status/ID byte at system initialisation.
// [RULE12] Firmware interrupt request drives the chosen interrupt line.
// [RULE13] Acknowledge on own level drops request and drives status/ID.
// [RULE14] Acknowledges for other levels pass down while input is low.
// [RULE15] System reset fully resets the block; self-test follows.
// [RULE16] Self-test fault lights the lamp and raises failure output.
// [RULE17] Watchdog not restarted within 2.5 seconds raises failure.
// [RULE18] After failure, all further commands are refused until reset.
// [RULE19] Host sends no commands within ten seconds after reset.
// [RULE20] Ready writes 01 at channel 1FF and clears all other places.
// [RULE21] Status/ID byte goes out on data lines 0 to 7.
// [RULE22] Address lines 1 to 3 select the acknowledged level.
// [RULE23] No transfer acknowledge within 64 microseconds aborts, releases bus.
// [RULE24] Asynchronous bus inputs pass two flip-flops before use.
package arb_pkg;
  // ===========================================================
  // Timing
  localparam int CLK_HZ       = 25_000_000;
  localparam int REQ_TO_MS    = 1000;
  localparam int WDOG_MS      = 2500;
  localparam int TENURE_US    = 64;
  localparam int DTACK_US     = 64;
  localparam int REQ_TO_CYC   = CLK_HZ / 1000 * REQ_TO_MS;
  localparam int WDOG_CYC     = CLK_HZ / 1000 * WDOG_MS;
  localparam int TENURE_CYC   = TENURE_US * (CLK_HZ / 1_000_000);
  localparam int DTACK_CYC    = DTACK_US * (CLK_HZ / 1_000_000);
  // ===========================================================
  // Register byte offsets
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_CONFIG = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [3:0] OFS_TENURE = 4'hc;
  // Control bits
  localparam int CT_DMA   = 0;
  localparam int CT_IRQ   = 1;
  localparam int CT_KICK  = 2;
  localparam int CT_FAULT = 3;
  localparam int CT_INIT  = 4;
  // Config fields
  localparam int CF_BLVL  = 0;
  localparam int CF_ILVL  = 4;
  localparam int CF_SID   = 8;
  // Status bits
  localparam int ST_OWN   = 0;
  localparam int ST_BRQ   = 1;
  localparam int ST_RTO   = 2;
  localparam int ST_IRQ   = 3;
  localparam int ST_FAIL  = 4;
  localparam int ST_DTO   = 5;
  localparam int ST_RDY   = 6;
  localparam int ST_TEN   = 7;
  // Reset values
  localparam logic [1:0] BLVL_RST = 2'h0;
  localparam logic [2:0] ILVL_RST = 3'h1;
  localparam logic [7:0] SID_RST  = 8'h00;
  // Command channel
  localparam logic [8:0] CC_LAST  = 9'h1ff;
  localparam logic [7:0] CC_READY = 8'h01;
  // ===========================================================
  // Bus pins sampled from the backplane
  typedef struct packed {
    logic [3:0] bgin_n;
    logic       as_n;
    logic       iack_n;
    logic       iackin_n;
    logic       ds0_n;
    logic       dtack_n;
    logic [2:0] addr;
    logic       failure_jumper;
  } bus_in_s;
  // Command channel write port
  typedef struct packed {
    logic       we;
    logic [8:0] addr;
    logic [7:0] wdata;
  } cc_wr_s;
  typedef enum logic [4:0] {
    RQ_IDLE = 5'b00001,
    RQ_REQ  = 5'b00010,
    RQ_WAS  = 5'b00100,
    RQ_OWN  = 5'b01000,
    RQ_REL  = 5'b10000
  } rq_state_e;
  typedef enum logic [2:0] {
    IA_IDLE = 3'b001,
    IA_RESP = 3'b010,
    IA_PASS = 3'b100
  } ia_state_e;
endpackage

// >>> design/vme_requester_interrupter.sv
// Bus requester, interrupter and failure supervision
//
// Decided for this implementation: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module vme_requester_interrupter
  import arb_pkg::*;
#(
  parameter int REQ_TO  = REQ_TO_CYC,
  parameter int WDOG_TO = WDOG_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Backplane inputs
  input  wire bus_in_s     pins_in,
  // Local DMA master cycle in progress
  input  wire logic        dma_cycle,
  // Arbitration outputs
  output logic      [3:0]  br_oe,
  output logic      [3:0]  bgout_n,
  output logic             bbsy_oe,
  output logic             master_en,
  // Interrupter outputs
  output logic      [6:0]  irq_oe,
  output logic             iackout_n,
  output logic      [7:0]  data_out,
  output logic             data_oe,
  output logic             dtack_oe,
  // Failure and command channel
  output logic             sysfail_oe,
  output logic             fail_led,
  output cc_wr_s           cc_wr
);
  // ===========================================================
  // Parameter checks
  if (REQ_TO < 2 || WDOG_TO < 2) begin : g_chk
    $error("Time-out counts must be at least 2");
  end

  // ===========================================================
  // Input synchronisers
  bus_in_s sync1_q;
  bus_in_s s;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= '1;
      s       <= '1;
    end else begin
      sync1_q <= pins_in; // RULE24
      s       <= sync1_q; // RULE24
    end
  end

  // ===========================================================
  // Registers
  logic        dma_q;
  logic        irq_req_q;
  logic        fail_q;
  logic        rto_q;
  logic        dto_q;
  logic        ten_q;
  logic        ready_q;
  logic [1:0]  blvl_q;
  logic [2:0]  ilvl_q;
  logic [7:0]  sid_q;
  logic        wr_ok;
  logic        kick;
  logic        init_go;
  logic        grant;
  logic        rto_set;
  logic        dto_set;
  logic        ten_set;
  logic        ack_hit;
  logic [31:0] rd_d;
  logic [31:0] req_cnt_q;
  logic [31:0] wd_cnt_q;
  logic [10:0] ten_cnt_q;
  logic [10:0] dtk_cnt_q;
  logic        clr_busy_q;
  rq_state_e   rq_q;
  ia_state_e   ia_q;

  // Write taken at the edge where waitrequest is seen low
  assign wr_ok   = avs_write && !avs_waitrequest;
  assign kick    = wr_ok && avs_address == OFS_CTRL && avs_byteenable[0]
                   && avs_writedata[CT_KICK];
  assign init_go = wr_ok && avs_address == OFS_CTRL && avs_byteenable[0]
                   && avs_writedata[CT_INIT] && !fail_q;
  assign grant   = !s.bgin_n[blvl_q];
  assign ack_hit = ia_q == IA_IDLE && !s.iackin_n && !s.iack_n
                   && irq_req_q && ilvl_q != 3'h0
                   && s.addr == ilvl_q; // RULE22

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= avs_read ? rd_d : 32'h0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  always_comb begin
    rd_d = 32'h0;
    case (avs_address)
      OFS_CTRL: begin
        rd_d[CT_DMA] = dma_q;
        rd_d[CT_IRQ] = irq_req_q;
      end
      OFS_CONFIG: begin
        rd_d[CF_BLVL +: 2] = blvl_q;
        rd_d[CF_ILVL +: 3] = ilvl_q;
        rd_d[CF_SID +: 8]  = sid_q;
      end
      OFS_STATUS: begin
        rd_d[ST_OWN]  = bbsy_oe;
        rd_d[ST_BRQ]  = |br_oe;
        rd_d[ST_RTO]  = rto_q;
        rd_d[ST_IRQ]  = |irq_oe;
        rd_d[ST_FAIL] = fail_q;
        rd_d[ST_DTO]  = dto_q;
        rd_d[ST_RDY]  = ready_q;
        rd_d[ST_TEN]  = ten_q;
      end
      OFS_TENURE: rd_d[10:0] = ten_cnt_q;
      default:    rd_d = 32'h0;
    endcase
  end

  // Configuration, refused after failure
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blvl_q <= BLVL_RST;
      ilvl_q <= ILVL_RST;
      sid_q  <= SID_RST;
    end else if (wr_ok && avs_address == OFS_CONFIG && !fail_q) begin // RULE18
      if (avs_byteenable[0]) begin
        blvl_q <= avs_writedata[CF_BLVL +: 2]; // RULE2
        ilvl_q <= avs_writedata[CF_ILVL +: 3]; // RULE10
      end
      if (avs_byteenable[1]) begin
        sid_q <= avs_writedata[CF_SID +: 8];
      end
    end
  end

  // Firmware DMA request; aborted by time-outs, set wins on write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dma_q <= 1'b0;
    end else if (fail_q) begin
      dma_q <= 1'b0; // RULE18
    end else if (wr_ok && avs_address == OFS_CTRL && avs_byteenable[0]) begin
      dma_q <= avs_writedata[CT_DMA];
    end else if (rto_set || dto_set) begin
      dma_q <= 1'b0; // RULE3 RULE23
    end
  end

  // Firmware interrupt request; cleared by acknowledge, set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_req_q <= 1'b0;
    end else if (fail_q) begin
      irq_req_q <= 1'b0;
    end else if (wr_ok && avs_address == OFS_CTRL && avs_byteenable[0]) begin
      irq_req_q <= avs_writedata[CT_IRQ];
    end else if (ack_hit) begin
      irq_req_q <= 1'b0; // RULE13
    end
  end

  // Sticky error flags, write one to clear, set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rto_q <= 1'b0;
      dto_q <= 1'b0;
      ten_q <= 1'b0;
    end else begin
      if (rto_set) begin
        rto_q <= 1'b1; // RULE3
      end else if (wr_ok && avs_address == OFS_STATUS
                   && avs_byteenable[0] && avs_writedata[ST_RTO]) begin
        rto_q <= 1'b0;
      end
      if (dto_set) begin
        dto_q <= 1'b1; // RULE23
      end else if (wr_ok && avs_address == OFS_STATUS
                   && avs_byteenable[0] && avs_writedata[ST_DTO]) begin
        dto_q <= 1'b0;
      end
      if (ten_set) begin
        ten_q <= 1'b1; // RULE6
      end else if (wr_ok && avs_address == OFS_STATUS
                   && avs_byteenable[0] && avs_writedata[ST_TEN]) begin
        ten_q <= 1'b0;
      end
    end
  end

  // ===========================================================
  // Bus requester
  assign rto_set = rq_q == RQ_REQ && req_cnt_q == REQ_TO - 1;
  assign dto_set = rq_q == RQ_OWN && dtk_cnt_q == 11'(DTACK_CYC - 1);
  assign ten_set = rq_q == RQ_OWN && ten_cnt_q == 11'(TENURE_CYC - 1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rq_q      <= RQ_IDLE;
      br_oe     <= 4'h0;
      bbsy_oe   <= 1'b0;
      master_en <= 1'b0;
      bgout_n   <= 4'hf;
    end else begin
      case (rq_q)
        RQ_IDLE: begin
          bgout_n          <= 4'hf;
          bgout_n[blvl_q]  <= !grant; // RULE9
          if (dma_q && !fail_q && !grant) begin
            br_oe         <= 4'h0;
            br_oe[blvl_q] <= 1'b1; // RULE1 RULE2
            rq_q          <= RQ_REQ;
          end
        end
        RQ_REQ: begin
          if (grant) begin // RULE4
            rq_q <= RQ_WAS;
          end
        end
        RQ_WAS: begin
          if (s.as_n) begin // RULE5
            br_oe     <= 4'h0;
            bbsy_oe   <= 1'b1;
            master_en <= 1'b1;
            rq_q      <= RQ_OWN;
          end
        end
        RQ_OWN: begin
          // Other requests and bus clear are not watched here
          if (!dma_q || ten_set || dto_set) begin // RULE6 RULE7 RULE23
            rq_q <= RQ_REL;
          end
        end
        RQ_REL: begin
          if (!grant) begin // RULE8
            bbsy_oe   <= 1'b0;
            master_en <= 1'b0;
            rq_q      <= RQ_IDLE;
          end
        end
        default: begin
          rq_q      <= RQ_IDLE;
          br_oe     <= 4'h0;
          bbsy_oe   <= 1'b0;
          master_en <= 1'b0;
          bgout_n   <= 4'hf;
        end
      endcase
    end
  end

  // Request, tenure and transfer acknowledge supervision
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_cnt_q <= 32'h0;
      ten_cnt_q <= 11'h0;
      dtk_cnt_q <= 11'h0;
    end else begin
      req_cnt_q <= (rq_q == RQ_REQ && !rto_set) ? req_cnt_q + 32'h1 : 32'h0;
      ten_cnt_q <= (rq_q == RQ_OWN) ? ten_cnt_q + 11'h1 : 11'h0;
      dtk_cnt_q <= (rq_q == RQ_OWN && dma_cycle && s.dtack_n)
                   ? dtk_cnt_q + 11'h1 : 11'h0;
    end
  end

  // ===========================================================
  // Interrupter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_oe <= 7'h0;
    end else begin
      irq_oe <= 7'h0;
      if (irq_req_q && !fail_q && ilvl_q != 3'h0) begin
        irq_oe[ilvl_q - 3'h1] <= 1'b1; // RULE10 RULE12
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ia_q      <= IA_IDLE;
      iackout_n <= 1'b1;
      data_out  <= 8'h0;
      data_oe   <= 1'b0;
      dtack_oe  <= 1'b0;
    end else begin
      case (ia_q)
        IA_IDLE: begin
          if (ack_hit) begin
            data_out <= sid_q; // RULE13 RULE21
            data_oe  <= 1'b1;
            ia_q     <= IA_RESP;
          end else if (!s.iackin_n) begin
            iackout_n <= 1'b0; // RULE14
            ia_q      <= IA_PASS;
          end
        end
        IA_RESP: begin
          dtack_oe <= !s.ds0_n;
          if (s.iackin_n) begin
            data_oe  <= 1'b0;
            dtack_oe <= 1'b0;
            ia_q     <= IA_IDLE;
          end
        end
        IA_PASS: begin
          if (s.iackin_n) begin
            iackout_n <= 1'b1; // RULE14
            ia_q      <= IA_IDLE;
          end
        end
        default: begin
          ia_q      <= IA_IDLE;
          iackout_n <= 1'b1;
          data_oe   <= 1'b0;
          dtack_oe  <= 1'b0;
        end
      endcase
    end
  end

  // ===========================================================
  // Watchdog and failure
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_cnt_q <= 32'h0;
    end else if (kick || fail_q) begin
      wd_cnt_q <= 32'h0;
    end else begin
      wd_cnt_q <= wd_cnt_q + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fail_q     <= 1'b0; // RULE15
      fail_led   <= 1'b0;
      sysfail_oe <= 1'b0;
    end else begin
      if ((wr_ok && avs_address == OFS_CTRL && avs_byteenable[0]
           && avs_writedata[CT_FAULT]) // RULE16
          || wd_cnt_q == WDOG_TO - 1) begin // RULE17
        fail_q <= 1'b1;
      end
      fail_led   <= fail_q; // RULE16
      sysfail_oe <= fail_q && s.failure_jumper; // RULE16
    end
  end

  // ===========================================================
  // Command channel clear and ready mark
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clr_busy_q <= 1'b0;
      ready_q    <= 1'b0;
      cc_wr      <= '0;
    end else begin
      cc_wr.we <= 1'b0;
      if (init_go && !clr_busy_q) begin
        clr_busy_q  <= 1'b1;
        ready_q     <= 1'b0;
        cc_wr.we    <= 1'b1;
        cc_wr.addr  <= 9'h0;
        cc_wr.wdata <= 8'h00;
      end else if (clr_busy_q) begin
        if (cc_wr.addr == CC_LAST) begin
          clr_busy_q <= 1'b0;
          ready_q    <= 1'b1; // RULE20
        end else begin
          cc_wr.we    <= 1'b1;
          cc_wr.addr  <= cc_wr.addr + 9'h1;
          cc_wr.wdata <= (cc_wr.addr + 9'h1 == CC_LAST) ? CC_READY : 8'h00;
        end
      end
    end
  end

  // ===========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_br_follows;
    rq_q == RQ_IDLE && dma_q && !fail_q && !grant |=> br_oe[blvl_q];
  endproperty
  a_br_follows: assert property (p_br_follows) // RULE1
    else $error("Bus request not raised");

  property p_br_held;
    rq_q == RQ_REQ && !grant |=> |br_oe;
  endproperty
  a_br_held: assert property (p_br_held) // RULE4
    else $error("Bus request dropped before grant");

  property p_take_bus;
    $rose(bbsy_oe) |-> $past(s.as_n) && br_oe == 4'h0 && master_en;
  endproperty
  a_take_bus: assert property (p_take_bus) // RULE5
    else $error("Busy taken without strobe idle");

  property p_tenure;
    rq_q == RQ_OWN |-> ten_cnt_q < 11'(TENURE_CYC);
  endproperty
  a_tenure: assert property (p_tenure) // RULE6
    else $error("Tenure too long");

  property p_release;
    $fell(bbsy_oe) |-> $past(!grant) && !master_en;
  endproperty
  a_release: assert property (p_release) // RULE8
    else $error("Busy released with grant active");

  property p_pass_grant;
    rq_q == RQ_IDLE && grant && !dma_q |=> !bgout_n[$past(blvl_q)];
  endproperty
  a_pass_grant: assert property (p_pass_grant) // RULE9
    else $error("Grant not passed on");

  property p_irq_out;
    irq_req_q && !fail_q && ilvl_q != 3'h0 |=> |irq_oe;
  endproperty
  a_irq_out: assert property (p_irq_out) // RULE12
    else $error("Interrupt line not driven");

  property p_ack_resp;
    ia_q == IA_RESP && $past(ia_q) == IA_RESP
      |-> data_oe && data_out == sid_q && irq_oe == 7'h0;
  endproperty
  a_ack_resp: assert property (p_ack_resp) // RULE13
    else $error("Bad acknowledge response");

  property p_iack_pass;
    ia_q == IA_PASS |-> !iackout_n && !data_oe;
  endproperty
  a_iack_pass: assert property (p_iack_pass) // RULE14
    else $error("Acknowledge not passed on");

  property p_wdog;
    wd_cnt_q == WDOG_TO - 1 |=> fail_q ##1 fail_led;
  endproperty
  a_wdog: assert property (p_wdog) // RULE17
    else $error("Watchdog did not fail");

  property p_fail_stays;
    fail_q |=> fail_q && !dma_q && !irq_req_q;
  endproperty
  a_fail_stays: assert property (p_fail_stays) // RULE18
    else $error("Failure not latched");

  property p_ready;
    $rose(ready_q) |-> $past(cc_wr.we) && $past(cc_wr.addr) == CC_LAST
                       && $past(cc_wr.wdata) == CC_READY;
  endproperty
  a_ready: assert property (p_ready) // RULE20
    else $error("Ready without mark write");

  c_tenure: cover property (rq_q == RQ_REL ##[1:20] rq_q == RQ_IDLE);
  c_ack:    cover property (ia_q == IA_RESP);
  c_pass:   cover property (ia_q == IA_PASS ##1 ia_q == IA_IDLE);
  c_ready:  cover property ($rose(ready_q));
endmodule

// >>> dv/vme_far_side.sv
// Behavioural arbiter and interrupt handler facing the block
`timescale 1ns/1ps
module vme_far_side (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Block outputs
  input  wire logic [3:0] br_oe,
  input  wire logic       bbsy_oe,
  input  wire logic [6:0] irq_oe,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe,
  // Bench controls
  input  wire logic       grant_en,
  input  wire logic       pass_go,
  input  wire logic [1:0] pass_lvl,
  input  wire logic       ack_go,
  input  wire logic [2:0] ack_lvl,
  // Backplane drive and the status/ID byte received
  output logic      [3:0] bgin_n,
  output logic            as_n,
  output logic            iack_n,
  output logic            iackin_n,
  output logic            ds0_n,
  output logic      [2:0] addr,
  output logic            id_seen,
  output logic      [7:0] id_val
);
  logic [2:0] ac_q;
  logic [3:0] hold_q;
  logic [2:0] lvl;
  always_comb begin
    lvl = 3'h0;
    for (int k = 0; k < 7; k++) if (irq_oe[k]) lvl = 3'(k + 1);
  end
  // ==========================================================
  // Arbiter: grant until busy is taken; old master ends late
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bgin_n <= 4'hf;
      ac_q <= 3'h0;
      as_n <= 1'b0;
    end else begin
      bgin_n <= ~(((grant_en && !bbsy_oe) ? br_oe : 4'h0)
                | (pass_go ? 4'h1 << pass_lvl : 4'h0));
      ac_q <= (bgin_n == 4'hf) ? 3'h0 : ac_q + 3'(ac_q != 3'h7);
      as_n <= (ac_q >= 3'h4);
    end
  end
  // ==========================================================
  // Handler: acknowledge, take the byte, back off a while
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {iack_n, iackin_n, ds0_n} <= 3'h7;
      addr <= 3'h0;
      hold_q <= 4'h0;
      id_seen <= 1'b0;
      id_val <= 8'h00;
    end else begin
      id_seen <= 1'b0;
      if (hold_q != 4'h0) hold_q <= hold_q - 4'h1;
      if (!iackin_n && data_oe) begin
        id_seen <= 1'b1;
        id_val <= data_out;
        {iack_n, iackin_n, ds0_n} <= 3'h7;
        hold_q <= 4'hf;
      end else if (iackin_n && hold_q == 4'h0 && (lvl != 3'h0 || ack_go)) begin
        {iack_n, iackin_n, ds0_n} <= 3'h0;
        addr <= ack_go ? ack_lvl : lvl;
      end else if (!iackin_n && !ack_go && lvl == 3'h0) begin
        {iack_n, iackin_n, ds0_n} <= 3'h7;
      end else if (iackin_n) begin
        addr <= ~addr;
      end
    end
  end
endmodule

// >>> dv/vme_requester_interrupter_tb_top.sv
// Self-checking bench of the bus requester and interrupter
`timescale 1ns/1ps
module vme_requester_interrupter_tb_top
  import arb_pkg::*;
;
  logic        clk, rst_n, avs_read, avs_write, dma_cycle, jumper;
  logic [3:0]  avs_address, avs_byteenable, br_oe, bgout_n, bgin_n;
  logic [31:0] avs_writedata, avs_readdata, rnd;
  logic        avs_waitrequest, bbsy_oe, master_en, iackout_n, data_oe;
  logic        dtack_oe, sysfail_oe, fail_led, id_seen, grant_en, pass_go;
  logic        ack_go, as_n, iack_n, iackin_n, ds0_n, dtk_n;
  logic [6:0]  irq_oe;
  logic [7:0]  data_out, id_val, sid;
  logic [1:0]  pass_lvl;
  logic [2:0]  ack_lvl, addr;
  bus_in_s     pins_in;
  cc_wr_s      cc_wr;
  logic [31:0] q_rd[$], q_id[$];
  int          n_fail, check_count, cyc, n_cc, i;
  assign pins_in = {bgin_n, as_n, iack_n, iackin_n, ds0_n, dtk_n, addr,
                    jumper};
  vme_requester_interrupter #(.REQ_TO(50), .WDOG_TO(4000)) dut_u (
    .clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_byteenable,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .pins_in, .dma_cycle,
    .br_oe, .bgout_n, .bbsy_oe, .master_en, .irq_oe, .iackout_n, .data_out,
    .data_oe, .dtack_oe, .sysfail_oe, .fail_led, .cc_wr);
  vme_far_side far_u (
    .clk, .rst_n, .br_oe, .bbsy_oe, .irq_oe, .data_out, .data_oe, .grant_en,
    .pass_go, .pass_lvl, .ack_go, .ack_lvl, .bgin_n, .as_n, .iack_n,
    .iackin_n, .ds0_n, .addr, .id_seen, .id_val);
  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_write <= wr;
    avs_read <= !wr;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    q_rd.push_back(exp);
    bus(1'b0, a, 32'h0);
  endtask
  // ==========================================================
  // Clock, random traffic, timeout and result monitor
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    rnd <= xs(rnd);
    dma_cycle <= rnd[0] | dtk_n;
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end
  always @(negedge clk) begin
    if (avs_read && avs_waitrequest === 1'b0) chk(avs_readdata, q_rd.pop_front());
    if (id_seen === 1'b1) chk(id_val, q_id.pop_front());
    if (cc_wr.we === 1'b1) begin
      chk({cc_wr.addr, cc_wr.wdata}, {n_cc[8:0], n_cc == 511 ? CC_READY : 8'h00});
      n_cc++;
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    {rst_n, avs_read, avs_write, dma_cycle, pass_go, ack_go, dtk_n} = '0;
    {avs_address, avs_writedata, pass_lvl, ack_lvl} = '0;
    {avs_byteenable, jumper, grant_en, rnd} = {4'hf, 2'b11, 32'd99};
    {n_fail, check_count, cyc, n_cc} = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk({avs_waitrequest, br_oe, bgout_n, irq_oe, iackout_n, fail_led},
        {1'b1, 4'h0, 4'hf, 7'h0, 1'b1, 1'b0});
    bus(1'b1, OFS_CTRL, 32'h14);
    repeat (5) begin
      repeat (100) @(posedge clk);
      bus(1'b1, OFS_CTRL, 32'h04);
    end
    chk(n_cc, 512);
    rd(OFS_STATUS, 32'h40);
    rd(4'h2, 32'h0);
    for (int l = 0; l < 4; l++) begin
      sid = rnd[15:8];
      bus(1'b1, OFS_CONFIG, {16'h0, sid, 8'h10 | 8'(l)});
      rd(OFS_CONFIG, {16'h0, sid, 8'h10 | 8'(l)});
      bus(1'b1, OFS_CTRL, 32'h05);
      repeat (2) @(negedge clk);
      chk({br_oe, bgout_n}, {4'h1 << l, 4'hf});
      for (i = 0; i < 40 && bbsy_oe !== 1'b1; i++) @(negedge clk);
      chk({bbsy_oe, master_en, br_oe}, 6'h30);
      bus(1'b1, OFS_CTRL, 32'h04);
      for (i = 0; i < 40 && bbsy_oe !== 1'b0; i++) @(negedge clk);
      chk({bbsy_oe, master_en, br_oe}, 6'h00);
    end
    for (int l = 1; l < 8; l++) begin
      sid = rnd[7:0];
      bus(1'b1, OFS_CONFIG, {16'h0, sid, 1'b0, 3'(l), 4'h0});
      q_id.push_back(sid);
      bus(1'b1, OFS_CTRL, 32'h06);
      repeat (2) @(negedge clk);
      chk(irq_oe, 7'h1 << (l - 1));
      for (i = 0; i < 40 && irq_oe !== 7'h0; i++) @(negedge clk);
      chk({irq_oe, iackout_n, data_oe, dtack_oe}, 10'h007);
      repeat (20) @(negedge clk);
    end
    bus(1'b1, OFS_CONFIG, 32'h23);
    @(posedge clk);
    {pass_lvl, pass_go, ack_lvl, ack_go} <= {2'h3, 1'b1, 3'h5, 1'b1};
    repeat (8) @(negedge clk);
    chk({bgout_n, iackout_n, data_oe}, 6'h1c);
    @(posedge clk);
    {pass_go, ack_go} <= 2'b00;
    repeat (8) @(negedge clk);
    chk({bgout_n, iackout_n}, 5'h1f);
    @(posedge clk);
    grant_en <= 1'b0;
    bus(1'b1, OFS_CTRL, 32'h05);
    repeat (60) @(negedge clk);
    chk(br_oe, 4'h8);
    rd(OFS_STATUS, 32'h46);
    grant_en <= 1'b1;
    for (i = 0; i < 80 && bbsy_oe !== 1'b1; i++) @(negedge clk);
    for (i = 0; i < 80 && bbsy_oe !== 1'b0; i++) @(negedge clk);
    chk({bbsy_oe, br_oe}, 5'h0);
    bus(1'b1, OFS_CTRL, 32'h05);
    for (i = 0; i < 80 && bbsy_oe !== 1'b1; i++) @(negedge clk);
    for (i = 0; i < 2000 && bbsy_oe === 1'b1; i++) @(negedge clk);
    chk(i, TENURE_CYC + 1);
    @(posedge clk);
    dtk_n <= 1'b1;
    for (i = 0; i < 80 && bbsy_oe !== 1'b1; i++) @(negedge clk);
    for (i = 0; i < 2000 && bbsy_oe === 1'b1; i++) @(negedge clk);
    chk(i, DTACK_CYC + 1);
    rd(OFS_CTRL, 32'h0);
    rd(OFS_STATUS, 32'he4);
    bus(1'b1, OFS_STATUS, 32'ha4);
    rd(OFS_STATUS, 32'h40);
    bus(1'b1, OFS_CTRL, 32'h08);
    repeat (3) @(negedge clk);
    chk({fail_led, sysfail_oe}, 2'b11);
    bus(1'b1, OFS_CTRL, 32'h05);
    repeat (10) @(negedge clk);
    chk(br_oe, 4'h0);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3900) @(negedge clk);
    chk({fail_led, sysfail_oe}, 2'b00);
    repeat (200) @(negedge clk);
    chk(fail_led, 1'b1);
    finish_test();
  end
endmodule
